// >>> cmmn_regs.svh
`ifndef CMMN_REGS_SVH
`define CMMN_REGS_SVH

// ==========================================================
// opcode patterns of the first and second instruction words
`define CMMN_W0_STORE_PD   11'h036
`define CMMN_W1_STORE_PD   11'h478
`define CMMN_W0_TO_HOST    11'h033
`define CMMN_W1_TO_HOST    16'h4F00
`define CMMN_W0_LOAD_MUL   11'h032
`define CMMN_W1_LMUL_F     11'h288
`define CMMN_W1_LMUL_S     11'h280
`define CMMN_W0_LOAD_NEG   11'h031
`define CMMN_W1_LOAD_NEG   16'h5E00
`define CMMN_SH_MOVE_A     16'hD836
`define CMMN_SH_MOVE_B     16'hD83A
`define CMMN_SH_MUL_D      16'hD823
`define CMMN_SH_MUL_F      16'hD822
`define CMMN_SH_MUL_S      16'hD820
`define CMMN_SH_NEG        16'hD83C
`define CMMN_FN_MOVE       4'h1
`define CMMN_FN_NEG        4'h3

// ==========================================================
// final word field positions
`define CMMN_ID_MSB        15
`define CMMN_ID_LSB        13
`define CMMN_S1_MSB        12
`define CMMN_S1_LSB        9
`define CMMN_S2_MSB        8
`define CMMN_S2_LSB        5
`define CMMN_RD_MSB        4
`define CMMN_RD_LSB        0

// ==========================================================
// machine state counts and transfer figures
`define CMMN_ST_STORE_AL   6'h05
`define CMMN_ST_STORE_NA   6'h06
`define CMMN_ST_HOST_AL    6'h05
`define CMMN_ST_HOST_NA    6'h04
`define CMMN_ST_LOAD_AL    6'h04
`define CMMN_ST_LOAD_NA    6'h03
`define CMMN_ST_SHORT      6'h02
`define CMMN_XFER_BITS     32'h0000_0020
`define CMMN_MAX_XFER      6'h20
`define CMMN_MSTATE_CYCLES 2

`endif

// >>> cmmn_pkg.sv
package cmmn_pkg;

  typedef enum logic [3:0] {
    op_none,
    copro_store_pd,
    copro_to_host,
    copro_float_move_a,
    copro_float_move_b,
    double_product_op,
    single_product_op,
    integer_product_op,
    load_single_product_op,
    load_integer_product_op,
    twos_complement_op,
    load_twos_complement_op
  } cmmn_op_e;

  typedef enum logic [1:0] {
    copro_execute_type,
    host_to_copro_type,
    copro_to_memory_type
  } cmmn_xfer_e;

  typedef enum logic [0:0] {
    fsm_idle,
    fsm_run
  } cmmn_fsm_e;

endpackage : cmmn_pkg

// >>> cmmn_mul_if.sv
`timescale 1ns/1ps
interface cmmn_mul_if #(parameter int W = 32);
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic [W-1:0] p;
  modport user (output a, output b, input p);
  modport unit (input a, input b, output p);
endinterface : cmmn_mul_if

// >>> cmmn_fmul.sv
`timescale 1ns/1ps
// ==========================================================
// floating multiply, truncating, no denormals
module cmmn_fmul #(
  parameter int EW = 8,
  parameter int MW = 23
) (
  cmmn_mul_if.unit mul
);
  localparam int W = 1 + EW + MW;
  localparam logic [EW+1:0] BIAS = {3'b000, {(EW-1){1'b1}}};
  localparam logic [EW+1:0] EMAX = {2'b00, {EW{1'b1}}};

  always_comb begin
    logic            sgn;
    logic [EW-1:0]   ea;
    logic [EW-1:0]   eb;
    logic [2*MW+1:0] prod;
    logic [EW+1:0]   e;
    logic [MW-1:0]   frac;
    sgn  = mul.a[W-1] ^ mul.b[W-1];
    ea   = mul.a[W-2:MW];
    eb   = mul.b[W-2:MW];
    prod = {1'b1, mul.a[MW-1:0]} * {1'b1, mul.b[MW-1:0]};
    e    = {2'b00, ea} + {2'b00, eb} - BIAS
           + {{(EW+1){1'b0}}, prod[2*MW+1]};
    frac = prod[2*MW+1] ? prod[2*MW:MW+1] : prod[2*MW-1:MW];
    // zero operand or underflow flushes to signed zero
    if (ea == '0 || eb == '0 || e[EW+1] || e == '0) begin
      mul.p = {sgn, {(W-1){1'b0}}};
    end else if (e >= EMAX) begin
      mul.p = {sgn, {EW{1'b1}}, {MW{1'b0}}};
    end else begin
      mul.p = {sgn, e[EW-1:0], frac};
    end
  end
endmodule : cmmn_fmul

// >>> cmmn_tick.sv
`timescale 1ns/1ps
// ==========================================================
// machine state enable divider
module cmmn_tick #(
  parameter int DIV = 2
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic clear_in,
  output logic      tick_out
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (clear_in || cnt == LAST) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // restarted on every command so state lengths stay exact
  assign tick_out = !clear_in && (cnt == LAST);
endmodule : cmmn_tick

// >>> cmmn_core.sv
`timescale 1ns/1ps
`include "cmmn_regs.svh"

module cmmn_core
  import cmmn_pkg::*;
#(
  parameter int MSTATE_CYCLES = `CMMN_MSTATE_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // instruction words
  input  wire logic        cmd_valid_in,
  input  wire logic [15:0] cmd_word0_in,
  input  wire logic [15:0] cmd_word1_in,
  input  wire logic [15:0] cmd_word2_in,
  input  wire logic        cmd_aligned_in,
  output logic             cmd_ready_out,
  output logic             done_out,
  output logic             illegal_out,
  output cmmn_xfer_e       xfer_type_out,
  output logic [1:0]       xfer_nregs_out,
  output logic [2:0]       copro_id_out,
  // host register file
  output logic [4:0]       host_rd_idx_out,
  input  wire logic [31:0] host_rd_data_in,
  output logic             host_wr_en_out,
  output logic [4:0]       host_wr_idx_out,
  output logic [31:0]      host_wr_data_out,
  // memory write
  output logic             mem_wr_en_out,
  output logic [31:0]      mem_addr_out,
  output logic [31:0]      mem_data_out,
  // coprocessor register observation
  input  wire logic [4:0]  dbg_idx_in,
  output logic [63:0]      dbg_data_out
);
  // ==========================================================
  // state
  cmmn_fsm_e   fsm,   next_fsm;
  cmmn_op_e    op,    next_op;
  logic [5:0]  total, next_total;
  logic [5:0]  step,  next_step;
  logic [5:0]  nxfer, next_nxfer;
  logic [4:0]  ptr,   next_ptr;
  logic [3:0]  src_a, next_src_a;
  logic [3:0]  src_b, next_src_b;
  logic [4:0]  hreg_a, next_hreg_a;
  logic [4:0]  hreg_b, next_hreg_b;
  logic [31:0] addr,  next_addr;
  logic        next_ready, next_done, next_illegal;
  cmmn_xfer_e  next_xfer;
  logic [1:0]  next_nregs;
  logic [2:0]  next_id;
  logic [4:0]  next_rd_idx, next_wr_idx;
  logic        next_wr_en, next_mem_en;
  logic [31:0] next_wr_data, next_mem_addr, next_mem_data;

  // copro register file: A0..A15 then B0..B15
  logic [63:0] crf [0:31];
  logic        cp_we;
  logic [4:0]  cp_widx;
  logic [63:0] cp_wdata;

  cmmn_op_e    dec_op;
  logic [5:0]  dec_total, dec_nxfer;
  logic [15:0] dec_fin;
  cmmn_xfer_e  dec_xfer;
  logic [1:0]  dec_nregs;
  logic        tick;
  logic [63:0] rf_a, rf_b;
  logic [31:0] step_addr;

  cmmn_mul_if #(.W(32)) mul_s ();
  cmmn_mul_if #(.W(64)) mul_d ();

  cmmn_fmul #(.EW(8), .MW(23)) u_fmul_s (
    .mul (mul_s.unit)
  );
  cmmn_fmul #(.EW(11), .MW(52)) u_fmul_d (
    .mul (mul_d.unit)
  );
  cmmn_tick #(.DIV(MSTATE_CYCLES)) u_tick (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .clear_in   (fsm != fsm_run),
    .tick_out   (tick)
  );

  assign rf_a      = crf[{1'b0, src_a}];
  assign rf_b      = crf[{1'b1, src_b}];
  assign mul_s.a   = rf_a[31:0];
  assign mul_s.b   = rf_b[31:0];
  assign mul_d.a   = rf_a;
  assign mul_d.b   = rf_b;
  assign step_addr = ((step == 6'h00) ? host_rd_data_in : addr)
                     - `CMMN_XFER_BITS;

  // ==========================================================
  // instruction decode
  always_comb begin
    dec_op    = op_none;
    dec_total = 6'h00;
    dec_nxfer = 6'h00;
    dec_fin   = cmd_word2_in;
    dec_xfer  = copro_execute_type;
    dec_nregs = 2'h0;
    if (cmd_word0_in[15:5] == `CMMN_W0_STORE_PD &&
        cmd_word1_in[15:5] == `CMMN_W1_STORE_PD) begin
      dec_op    = copro_store_pd;
      dec_nxfer = (cmd_word1_in[4:0] == 5'h00) ? `CMMN_MAX_XFER :
                  {1'b0, cmd_word1_in[4:0]};
      dec_total = (cmd_aligned_in ? `CMMN_ST_STORE_AL :
                  `CMMN_ST_STORE_NA) + dec_nxfer - 6'h01;
      dec_xfer  = copro_to_memory_type;
    end else if (cmd_word0_in[15:5] == `CMMN_W0_TO_HOST &&
                 cmd_word1_in == `CMMN_W1_TO_HOST) begin
      dec_op    = copro_to_host;
      dec_total = cmd_aligned_in ? `CMMN_ST_HOST_AL : `CMMN_ST_HOST_NA;
      dec_xfer  = host_to_copro_type;
      dec_nregs = 2'h1;
    end else if (cmd_word0_in[15:5] == `CMMN_W0_LOAD_MUL &&
                 (cmd_word1_in[15:5] == `CMMN_W1_LMUL_F ||
                  cmd_word1_in[15:5] == `CMMN_W1_LMUL_S)) begin
      dec_op    = (cmd_word1_in[15:5] == `CMMN_W1_LMUL_F) ?
                  load_single_product_op : load_integer_product_op;
      dec_total = cmd_aligned_in ? `CMMN_ST_LOAD_AL : `CMMN_ST_LOAD_NA;
      dec_xfer  = host_to_copro_type;
      dec_nregs = 2'h2;
    end else if (cmd_word0_in[15:5] == `CMMN_W0_LOAD_NEG &&
                 cmd_word1_in == `CMMN_W1_LOAD_NEG &&
                 cmd_word2_in[`CMMN_S2_MSB:`CMMN_S2_LSB] == `CMMN_FN_NEG)
    begin
      dec_op    = load_twos_complement_op;
      dec_total = cmd_aligned_in ? `CMMN_ST_LOAD_AL : `CMMN_ST_LOAD_NA;
      dec_xfer  = host_to_copro_type;
      dec_nregs = 2'h1;
    end else begin
      dec_fin   = cmd_word1_in;
      dec_total = `CMMN_ST_SHORT;
      if (cmd_word0_in == `CMMN_SH_MOVE_A &&
          cmd_word1_in[`CMMN_S2_MSB:`CMMN_S2_LSB] == `CMMN_FN_MOVE) begin
        dec_op = copro_float_move_a;
      end else if (cmd_word0_in == `CMMN_SH_MOVE_B &&
          cmd_word1_in[`CMMN_S2_MSB:`CMMN_S2_LSB] == `CMMN_FN_MOVE) begin
        dec_op = copro_float_move_b;
      end else if (cmd_word0_in == `CMMN_SH_MUL_D) begin
        dec_op = double_product_op;
      end else if (cmd_word0_in == `CMMN_SH_MUL_F) begin
        dec_op = single_product_op;
      end else if (cmd_word0_in == `CMMN_SH_MUL_S) begin
        dec_op = integer_product_op;
      end else if (cmd_word0_in == `CMMN_SH_NEG &&
          cmd_word1_in[`CMMN_S2_MSB:`CMMN_S2_LSB] == `CMMN_FN_NEG) begin
        dec_op = twos_complement_op;
      end
    end
  end

  // ==========================================================
  // sequencer next values
  always_comb begin
    next_fsm      = fsm;
    next_op       = op;
    next_total    = total;
    next_step     = step;
    next_nxfer    = nxfer;
    next_ptr      = ptr;
    next_src_a    = src_a;
    next_src_b    = src_b;
    next_hreg_a   = hreg_a;
    next_hreg_b   = hreg_b;
    next_addr     = addr;
    next_ready    = cmd_ready_out;
    next_done     = 1'b0;
    next_illegal  = 1'b0;
    next_xfer     = xfer_type_out;
    next_nregs    = xfer_nregs_out;
    next_id       = copro_id_out;
    next_rd_idx   = host_rd_idx_out;
    next_wr_en    = 1'b0;
    next_wr_idx   = host_wr_idx_out;
    next_wr_data  = host_wr_data_out;
    next_mem_en   = 1'b0;
    next_mem_addr = mem_addr_out;
    next_mem_data = mem_data_out;
    cp_we         = 1'b0;
    cp_widx       = ptr;
    cp_wdata      = 64'h0000_0000_0000_0000;
    case (fsm)
      fsm_idle: begin
        next_ready = 1'b1;
        if (cmd_valid_in && cmd_ready_out) begin
          if (dec_op == op_none) begin
            // unknown encodings finish at once, flagged
            next_illegal = 1'b1;
            next_done    = 1'b1;
          end else begin
            next_fsm    = fsm_run;
            next_ready  = 1'b0;
            next_op     = dec_op;
            next_total  = dec_total;
            next_step   = 6'h00;
            next_nxfer  = dec_nxfer;
            next_xfer   = dec_xfer;
            next_nregs  = dec_nregs;
            next_id     = dec_fin[`CMMN_ID_MSB:`CMMN_ID_LSB];
            next_src_a  = dec_fin[`CMMN_S1_MSB:`CMMN_S1_LSB];
            next_src_b  = dec_fin[`CMMN_S2_MSB:`CMMN_S2_LSB];
            next_ptr    = dec_fin[`CMMN_RD_MSB:`CMMN_RD_LSB];
            next_hreg_a = cmd_word0_in[4:0];
            next_hreg_b = cmd_word1_in[4:0];
            next_rd_idx = cmd_word0_in[4:0];
          end
        end
      end
      fsm_run: begin
        if (tick) begin
          next_step = step + 6'h01;
          case (op)
            copro_store_pd: begin
              if (step >= total - nxfer) begin
                next_addr     = step_addr;
                next_mem_en   = 1'b1;
                next_mem_addr = step_addr;
                next_mem_data = crf[ptr][31:0];
                next_ptr      = ptr + 5'h01;
              end else if (step == 6'h00) begin
                next_addr = host_rd_data_in;
              end
              if (step == total - 6'h01) begin
                next_wr_en   = 1'b1;
                next_wr_idx  = hreg_a;
                next_wr_data = step_addr;
              end
            end
            load_single_product_op, load_integer_product_op: begin
              if (step == 6'h00) begin
                cp_we       = 1'b1;
                cp_widx     = {1'b0, src_a};
                cp_wdata    = {32'h0000_0000, host_rd_data_in};
                next_rd_idx = hreg_b;
              end else if (step == 6'h01) begin
                cp_we    = 1'b1;
                cp_widx  = {1'b1, src_b};
                cp_wdata = {32'h0000_0000, host_rd_data_in};
              end
            end
            load_twos_complement_op: begin
              if (step == 6'h00) begin
                cp_we    = 1'b1;
                cp_widx  = {1'b0, src_a};
                cp_wdata = {32'h0000_0000, host_rd_data_in};
              end
            end
            default: begin
            end
          endcase
          if (step == total - 6'h01) begin
            next_fsm   = fsm_idle;
            next_ready = 1'b1;
            next_done  = 1'b1;
            cp_widx    = ptr;
            case (op)
              copro_to_host: begin
                next_wr_en   = 1'b1;
                next_wr_idx  = hreg_a;
                next_wr_data = crf[ptr][31:0];
              end
              copro_float_move_a: begin
                cp_we    = 1'b1;
                cp_wdata = {32'h0000_0000, rf_a[31:0]};
              end
              copro_float_move_b: begin
                cp_we    = 1'b1;
                cp_wdata = {32'h0000_0000, crf[{1'b1, src_a}][31:0]};
              end
              double_product_op: begin
                cp_we    = 1'b1;
                cp_wdata = mul_d.p;
              end
              single_product_op, load_single_product_op: begin
                cp_we    = 1'b1;
                cp_wdata = {32'h0000_0000, mul_s.p};
              end
              integer_product_op, load_integer_product_op: begin
                cp_we    = 1'b1;
                cp_wdata = {32'h0000_0000, 32'(rf_a[31:0] * rf_b[31:0])};
              end
              twos_complement_op, load_twos_complement_op: begin
                cp_we    = 1'b1;
                cp_wdata = {32'h0000_0000, 32'h0000_0000 - rf_a[31:0]};
              end
              default: begin
              end
            endcase
          end
        end
      end
      default: begin
        next_fsm = fsm_idle;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fsm              <= fsm_idle;
      op               <= op_none;
      total            <= 6'h00;
      step             <= 6'h00;
      nxfer            <= 6'h00;
      ptr              <= 5'h00;
      src_a            <= 4'h0;
      src_b            <= 4'h0;
      hreg_a           <= 5'h00;
      hreg_b           <= 5'h00;
      addr             <= 32'h0000_0000;
      cmd_ready_out    <= 1'b0;
      done_out         <= 1'b0;
      illegal_out      <= 1'b0;
      xfer_type_out    <= copro_execute_type;
      xfer_nregs_out   <= 2'h0;
      copro_id_out     <= 3'h0;
      host_rd_idx_out  <= 5'h00;
      host_wr_en_out   <= 1'b0;
      host_wr_idx_out  <= 5'h00;
      host_wr_data_out <= 32'h0000_0000;
      mem_wr_en_out    <= 1'b0;
      mem_addr_out     <= 32'h0000_0000;
      mem_data_out     <= 32'h0000_0000;
      dbg_data_out     <= 64'h0000_0000_0000_0000;
    end else begin
      fsm              <= next_fsm;
      op               <= next_op;
      total            <= next_total;
      step             <= next_step;
      nxfer            <= next_nxfer;
      ptr              <= next_ptr;
      src_a            <= next_src_a;
      src_b            <= next_src_b;
      hreg_a           <= next_hreg_a;
      hreg_b           <= next_hreg_b;
      addr             <= next_addr;
      cmd_ready_out    <= next_ready;
      done_out         <= next_done;
      illegal_out      <= next_illegal;
      xfer_type_out    <= next_xfer;
      xfer_nregs_out   <= next_nregs;
      copro_id_out     <= next_id;
      host_rd_idx_out  <= next_rd_idx;
      host_wr_en_out   <= next_wr_en;
      host_wr_idx_out  <= next_wr_idx;
      host_wr_data_out <= next_wr_data;
      mem_wr_en_out    <= next_mem_en;
      mem_addr_out     <= next_mem_addr;
      mem_data_out     <= next_mem_data;
      dbg_data_out     <= crf[dbg_idx_in];
    end
  end

  // data storage, no reset needed
  always_ff @(posedge clk_sys_in) begin
    if (cp_we) begin
      crf[cp_widx] <= cp_wdata;
    end
  end
endmodule : cmmn_core

// >>> cmmn_core_sva.sv
`timescale 1ns/1ps
`include "cmmn_regs.svh"
// ==========
// port checker, delays assume two cycles a state
module cmmn_core_sva
  import cmmn_pkg::*;
#(
  parameter int MSTATE_CYCLES = 2
) (
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // command side
  input wire logic        cmd_valid_in,
  input wire logic [15:0] cmd_word0_in,
  input wire logic [15:0] cmd_word1_in,
  input wire logic        cmd_aligned_in,
  input wire logic        cmd_ready_out,
  input wire logic        done_out,
  input wire cmmn_xfer_e  xfer_type_out,
  input wire logic [1:0]  xfer_nregs_out,
  // write side
  input wire logic        host_wr_en_out,
  input wire logic [31:0] host_wr_data_out,
  input wire logic        mem_wr_en_out,
  input wire logic [31:0] mem_addr_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_take(logic [10:0] op, logic c);
    cmd_valid_in && cmd_ready_out && cmd_word0_in[15:5] == op && c;
  endsequence
  sequence s_two_writes;
    mem_wr_en_out ##2 mem_wr_en_out;
  endsequence

  property p_step;
    s_two_writes |-> mem_addr_out == $past(mem_addr_out, 2) - 32'h20;
  endproperty
  property p_wb;
    mem_wr_en_out && done_out |->
      host_wr_en_out && host_wr_data_out == mem_addr_out;
  endproperty
  property p_store_n;
    s_take(`CMMN_W0_STORE_PD, cmd_aligned_in && cmd_word1_in[4:0] == 5'h02)
      |-> ##11 mem_wr_en_out ##2 (mem_wr_en_out && done_out);
  endproperty
  property p_host;
    s_take(`CMMN_W0_TO_HOST, cmd_aligned_in)
      |-> ##11 (done_out && host_wr_en_out);
  endproperty
  property p_load;
    s_take(`CMMN_W0_LOAD_MUL, !cmd_aligned_in)
      |-> ##1 (!done_out)[*6] ##1 done_out;
  endproperty
  property p_neg;
    s_take(11'h6C1, cmd_word0_in[4:0] == 5'h1C)
      |-> ##1 (!done_out)[*4] ##1 done_out;
  endproperty
  property p_type;
    s_take(`CMMN_W0_STORE_PD, 1'b1) |=> xfer_type_out == copro_to_memory_type;
  endproperty
  property p_two;
    s_take(`CMMN_W0_LOAD_MUL, 1'b1)
      |=> xfer_type_out == host_to_copro_type && xfer_nregs_out == 2'h2;
  endproperty

  a_step: assert property (p_step)
    else $error("store address step wrong");
  a_wb: assert property (p_wb)
    else $error("final address not written back");
  a_store_n: assert property (p_store_n)
    else $error("store write count or timing wrong");
  a_host: assert property (p_host)
    else $error("host move timing wrong");
  a_load: assert property (p_load)
    else $error("load multiply timing wrong");
  a_neg: assert property (p_neg)
    else $error("negate timing wrong");
  a_type: assert property (p_type)
    else $error("store transfer type wrong");
  a_two: assert property (p_two)
    else $error("load multiply transfer type wrong");
endmodule : cmmn_core_sva

bind cmmn_core cmmn_core_sva #(.MSTATE_CYCLES(MSTATE_CYCLES)) i_sva (
  .clk_sys_in, .rst_in, .cmd_valid_in, .cmd_word0_in, .cmd_word1_in,
  .cmd_aligned_in, .cmd_ready_out, .done_out, .xfer_type_out,
  .xfer_nregs_out, .host_wr_en_out, .host_wr_data_out, .mem_wr_en_out,
  .mem_addr_out
);

// >>> cmmn_host_model.sv
`timescale 1ns/1ps
// ==========
// host register file, read same cycle
module cmmn_host_model (
  // clock
  input  wire logic        clk_sys_in,
  // read and write ports
  input  wire logic [4:0]  rd_idx_in,
  output logic      [31:0] rd_data_out,
  input  wire logic        wr_en_in,
  input  wire logic [4:0]  wr_idx_in,
  input  wire logic [31:0] wr_data_in
);
  logic [31:0] regs [32];
  assign rd_data_out = regs[rd_idx_in];
  always @(posedge clk_sys_in) begin
    if (wr_en_in) regs[wr_idx_in] <= wr_data_in;
  end
endmodule : cmmn_host_model

// >>> test_copro_move_multiply_negate.sv
`timescale 1ns/1ps
`include "cmmn_regs.svh"
module test_copro_move_multiply_negate;
  import cmmn_pkg::*;
  typedef struct {logic [1:0] k; logic [31:0] a; logic [63:0] d;} cmmn_note_s;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cmd_valid_in = 1'b0;
  logic [15:0] cmd_word0_in = 16'h0000;
  logic [15:0] cmd_word1_in = 16'h0000;
  logic [15:0] cmd_word2_in = 16'h0000;
  logic        cmd_aligned_in = 1'b0;
  logic [4:0]  dbg_idx_in = 5'h00;
  logic        cmd_ready_out, done_out, illegal_out, host_wr_en_out;
  logic        mem_wr_en_out;
  cmmn_xfer_e  xfer_type_out;
  logic [1:0]  xfer_nregs_out;
  logic [2:0]  copro_id_out;
  logic [4:0]  host_rd_idx_out, host_wr_idx_out;
  logic [31:0] host_rd_data_in, host_wr_data_out, mem_addr_out, mem_data_out;
  logic [63:0] dbg_data_out;
  logic        pk = 1'b0;
  logic        pk_q = 1'b0;
  logic [31:0] hv [32];
  logic [63:0] cr [32];
  cmmn_note_s  q [$];
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          t0 = 0;

  cmmn_core i_dut (
    .clk_sys_in, .rst_in, .cmd_valid_in, .cmd_word0_in, .cmd_word1_in,
    .cmd_word2_in, .cmd_aligned_in, .cmd_ready_out, .done_out, .illegal_out,
    .xfer_type_out, .xfer_nregs_out, .copro_id_out, .host_rd_idx_out,
    .host_rd_data_in, .host_wr_en_out, .host_wr_idx_out, .host_wr_data_out,
    .mem_wr_en_out, .mem_addr_out, .mem_data_out, .dbg_idx_in, .dbg_data_out
  );
  cmmn_host_model i_host (
    .clk_sys_in, .rd_idx_in(host_rd_idx_out), .rd_data_out(host_rd_data_in),
    .wr_en_in(host_wr_en_out), .wr_idx_in(host_wr_idx_out),
    .wr_data_in(host_wr_data_out)
  );

  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cmd_valid_in && cmd_ready_out) t0 <= cyc;
    if (cyc > 5000) begin
      n_fail++;
      test_done();
    end
  end

  // ==========
  // comparison and drivers
  task automatic chk(input string s, input logic [63:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic chk_note(input logic [1:0] k, input logic [31:0] a,
                          input logic [63:0] d);
    cmmn_note_s n;
    if (q.size() == 0) begin
      chk("unexpected result", 64'h0, 64'h1);
      return;
    end
    n = q.pop_front();
    chk("kind", {62'h0, n.k}, {62'h0, k});
    chk("addr", {32'h0, n.a}, {32'h0, a});
    chk("data", n.d, d);
  endtask : chk_note

  task automatic run(input logic [15:0] a, b, c, input logic al,
                     input int lat, input logic [7:0] ty);
    int n;
    n = 0;
    q.push_back('{2'h0, {24'h0, ty}, 64'(lat)});
    @(posedge clk_sys_in);
    cmd_valid_in   <= 1'b1;
    cmd_word0_in   <= a;
    cmd_word1_in   <= b;
    cmd_word2_in   <= c;
    cmd_aligned_in <= al;
    @(posedge clk_sys_in);
    while (cmd_ready_out !== 1'b1) @(posedge clk_sys_in);
    cmd_valid_in <= 1'b0;
    while (done_out !== 1'b1 && n < 200) begin
      @(posedge clk_sys_in);
      n++;
    end
  endtask : run

  task automatic peek(input logic [4:0] i);
    q.push_back('{2'h3, 32'h0, cr[i]});
    @(posedge clk_sys_in);
    dbg_idx_in <= i;
    pk         <= 1'b1;
    @(posedge clk_sys_in);
    pk <= 1'b0;
  endtask : peek

  task automatic sh(input logic [15:0] op, input logic [3:0] s, f,
                    input logic [4:0] rd, input logic [63:0] e);
    cr[rd] = e;
    run(op, {3'h5, s, f, rd}, 16'h0000, 1'($urandom), 4, 8'hA0);
    peek(rd);
  endtask : sh

  task automatic th(input logic [4:0] rd, src, input logic al);
    hv[rd] = cr[src][31:0];
    q.push_back('{2'h2, {27'h0, rd}, {32'h0, hv[rd]}});
    run({`CMMN_W0_TO_HOST, rd}, `CMMN_W1_TO_HOST, {3'h5, 8'h00, src}, al,
        al ? 10 : 8, 8'hA5);
  endtask : th

  task automatic st(input logic [4:0] rd, n, p, input logic al);
    logic [4:0] p0;
    int         c;
    p0 = p;
    c = (n == 5'h00) ? 32 : int'(n);
    for (int i = 0; i < c; i++) begin
      hv[rd] = hv[rd] - 32'h20;
      q.push_back('{2'h1, hv[rd], {32'h0, cr[p][31:0]}});
      p = p + 5'h01;
    end
    q.push_back('{2'h2, {27'h0, rd}, {32'h0, hv[rd]}});
    run({`CMMN_W0_STORE_PD, rd}, {`CMMN_W1_STORE_PD, n}, {3'h5, 8'h00, p0},
        al, 2 * ((al ? 5 : 6) + c - 1), 8'hA8);
  endtask : st

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // ==========
  // result monitor
  initial forever begin
    logic [7:0] tv;
    @(posedge clk_sys_in);
    #1;
    if (mem_wr_en_out === 1'b1)
      chk_note(2'h1, mem_addr_out, {32'h0, mem_data_out});
    if (host_wr_en_out === 1'b1)
      chk_note(2'h2, 32'(host_wr_idx_out), {32'h0, host_wr_data_out});
    if (done_out === 1'b1) begin
      tv = {copro_id_out, illegal_out, xfer_type_out, xfer_nregs_out};
      // register count not defined for stores
      if (xfer_type_out == copro_to_memory_type) tv[1:0] = 2'h0;
      if (illegal_out !== 1'b0) tv = {3'h0, illegal_out, 4'h0};
      chk_note(2'h0, {24'h0, tv}, 64'(cyc - t0 - 1));
    end
    if (pk_q) chk_note(2'h3, 32'h0, dbg_data_out);
    pk_q = pk;
  end

  // ==========
  // main sequence
  initial begin
    logic [4:0] r;
    logic       al;
    void'($urandom(88));
    for (int i = 0; i < 32; i++) hv[i] = $urandom;
    hv[1]  = 32'h4000_0000;
    hv[2]  = 32'h4040_0000;
    hv[10] = 32'h0001_0000;
    for (int i = 0; i < 32; i++) i_host.regs[i] = hv[i];
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      r = 5'($urandom_range(31));
      al = 1'($urandom);
      cr[0] = {32'h0, hv[r]};
      cr[i] = {32'h0, -hv[r]};
      run({`CMMN_W0_LOAD_NEG, r}, `CMMN_W1_LOAD_NEG,
          {3'h5, 4'h0, `CMMN_FN_NEG, 5'(i)}, al, al ? 8 : 6, 8'hA5);
      peek(5'(i));
    end
    $display("test load negate done");
    cr[1]  = {32'h0, hv[1]};
    cr[18] = {32'h0, hv[2]};
    cr[3]  = 64'h0000_0000_40C0_0000;
    run({`CMMN_W0_LOAD_MUL, 5'h01}, {`CMMN_W1_LMUL_F, 5'h02},
        {3'h5, 4'h1, 4'h2, 5'h03}, 1'b0, 6, 8'hA6);
    peek(5'h03);
    cr[4]  = {32'h0, hv[4]};
    cr[21] = {32'h0, hv[21]};
    cr[20] = {32'h0, hv[4] * hv[21]};
    run({`CMMN_W0_LOAD_MUL, 5'h04}, {`CMMN_W1_LMUL_S, 5'h15},
        {3'h5, 4'h4, 4'h5, 5'h14}, 1'b1, 8, 8'hA6);
    peek(5'h14);
    $display("test load multiply done");
    sh(`CMMN_SH_MOVE_A, 4'h1, `CMMN_FN_MOVE, 5'h08, cr[1]);
    sh(`CMMN_SH_MOVE_B, 4'h2, `CMMN_FN_MOVE, 5'h09, cr[18]);
    sh(`CMMN_SH_MUL_F, 4'h1, 4'h2, 5'h0A, 64'h0000_0000_40C0_0000);
    sh(`CMMN_SH_MUL_S, 4'h4, 4'h5, 5'h0B, cr[20]);
    sh(`CMMN_SH_NEG, 4'h6, `CMMN_FN_NEG, 5'h0C, {32'h0, -cr[6][31:0]});
    sh(`CMMN_SH_MUL_D, 4'h1, 4'h2, 5'h0D, 64'h0);
    $display("test short forms done");
    th(5'h09, 5'h03, 1'b1);
    th(5'h0E, 5'h14, 1'b0);
    $display("test move to host done");
    st(5'h0A, 5'h02, 5'h03, 1'b1);
    st(5'h0A, 5'h00, 5'h1E, 1'b0);
    $display("test store done");
    run(16'hFFFF, 16'hFFFF, 16'hFFFF, 1'b0, 0, 8'h10);
    repeat (4) @(posedge clk_sys_in);
    chk("queue left", 64'h0, 64'(q.size()));
    $display("test illegal done");
    test_done();
  end
endmodule : test_copro_move_multiply_negate
